// [logic/apr_pkg.sv]
package apr_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] APR_IDX_DAC_PATH = 6'h05;
	localparam logic [5:0] APR_IDX_ROUTING = 6'h06;
	localparam logic [5:0] APR_IDX_MIX_BOOST = 6'h15;
	localparam logic [5:0] APR_IDX_LEFT_VOL = 6'h18;
	localparam int APR_IDX_LSB = 2;
	localparam int APR_IDX_W = 6;
	localparam int APR_REG_W = 16;

	// power and path enables
	localparam int APR_B_SECOND_DAC_L = 13;
	localparam int APR_B_SECOND_DAC_R = 12;
	localparam int APR_B_FIRST_DAC_L = 9;
	localparam int APR_B_FIRST_DAC_R = 8;
	localparam int APR_B_CONV_L = 1;
	localparam int APR_B_CONV_R = 0;
	localparam logic [15:0] APR_MASK_DAC_PATH = 16'h3303;
	localparam logic [15:0] APR_RST_DAC_PATH = 16'h0000;

	// routing fields
	localparam int APR_F_MONO_LSB = 9;
	localparam int APR_F_ROUTE_LSB = 7;
	localparam int APR_B_FLOAT = 5;
	localparam int APR_F_REC_PIN_LSB = 3;
	localparam int APR_B_SECOND_REC = 2;
	localparam int APR_B_SECOND_PLAY = 1;
	localparam int APR_B_FIRST_PLAY = 0;
	localparam logic [15:0] APR_MASK_ROUTING = 16'h07bf;
	localparam logic [15:0] APR_RST_ROUTING = 16'h0000;

	// input mixer
	localparam int APR_B_BOOST_R = 8;
	localparam int APR_B_BOOST_L = 7;
	localparam int APR_B_CLAMP = 6;
	localparam logic [15:0] APR_MASK_MIX_BOOST = 16'h01c0;
	localparam logic [15:0] APR_RST_MIX_BOOST = 16'h0000;

	// left input amplifier volume
	localparam int APR_B_COMMIT = 8;
	localparam int APR_B_MUTE = 7;
	localparam int APR_B_ZC = 6;
	localparam int APR_GAIN_W = 5;
	localparam logic [15:0] APR_MASK_LEFT_VOL = 16'h00df;
	localparam logic [15:0] APR_RST_LEFT_VOL = 16'h008b;
	localparam logic [4:0] APR_RST_GAIN = 5'h0b;

	// two-bit selector codes
	localparam logic [1:0] APR_MONO_NONE = 2'h0;
	localparam logic [1:0] APR_MONO_ADC_L = 2'h1;
	localparam logic [1:0] APR_MONO_ADC_R = 2'h2;
	localparam logic [1:0] APR_ROUTE_BOTH_SECOND = 2'h0;
	localparam logic [1:0] APR_ROUTE_R_THIRD = 2'h1;
	localparam logic [1:0] APR_ROUTE_L_THIRD = 2'h2;
	localparam logic [1:0] APR_REC_FIRST_ADC = 2'h0;
	localparam logic [1:0] APR_REC_SECOND_ADC = 2'h1;
	localparam logic [1:0] APR_REC_SECOND_DAC = 2'h2;
	localparam logic [1:0] APR_REC_MONO = 2'h3;

	// volume commit sequencing
	typedef enum logic [0:0] {
		APR_VOL_IDLE,
		APR_VOL_WAIT_ZC
	} apr_vol_e;
endpackage

// [logic/apr_regs.sv]
`timescale 1ns/1ps
// Functional notes
// RULE1 - second port left/right play paths enable
// RULE2 - first port left/right play paths enable
// RULE3 - mono output source select, code three reserved
// RULE4 - second port input route, code three reserved
// RULE5 - float bit releases third port pins
// RULE6 - float leaves non third port pins alone
// RULE7 - third port record pin source select
// RULE8 - pin nine must be assigned record data
// RULE9 - second port record and play sources
// RULE10 - first port play source select
// RULE11 - pin eight must be assigned play data
// RULE12 - right bypass boost sets +6/+15dB limit
// RULE13 - left bypass boost sets +6/+15dB limit
// RULE14 - input clamp on when bit set
// RULE15 - commit bit applies both amp volumes together
// RULE16 - left amp mute, resets muted
// RULE17 - zero cross gate delays gain change
// RULE18 - five bit left amp gain, resets 0_1011
// RULE19 - undefined bits zero, reserved codes unused
module apr_regs
	import apr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic first_play_pin,
	input wire logic second_play_pin,
	input wire logic shared_pin_eight_in,
	input wire logic first_rec_data,
	input wire logic second_rec_data,
	input wire logic second_adc_left,
	input wire logic second_adc_right,
	output logic first_dac_left_data,
	output logic first_dac_right_data,
	output logic second_dac_left_data,
	output logic second_dac_right_data,
	output logic second_rec_pin_data,
	input wire logic pin_nine_is_record,
	input wire logic pin_nine_alt_out,
	input wire logic pin_nine_alt_oe_n,
	output logic shared_pin_nine_out,
	output logic shared_pin_nine_oe_n,
	output logic left_converter_on,
	output logic right_converter_on,
	output logic right_bypass_gain_boost,
	output logic left_bypass_gain_boost,
	output logic inputs_clamp_on,
	input wire logic left_zero_cross,
	output logic left_input_amp_mute,
	output logic left_input_zero_cross_gate,
	output logic [APR_GAIN_W-1:0] left_input_amp_gain,
	output logic input_pair_volume_commit
);
	apr_route_if route_bus();

	logic [15:0] dac_path_power_control_ff;
	logic [15:0] port_routing_control_ff;
	logic [15:0] input_mixer_boost_control_ff;
	logic [15:0] left_input_pair_volume_ff;
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic [APR_GAIN_W-1:0] gain_ff;
	logic commit_ff;
	logic third_rec_data;
	apr_vol_e vol_state_ff;
	apr_vol_e nxt_vol_state;
	logic wr_req;
	logic rd_req;
	logic [APR_IDX_W-1:0] idx;
	logic commit_write;
	logic apply_now;

	// register index from a byte address
	function automatic logic [APR_IDX_W-1:0] reg_index(
		input logic [7:0] adr
	);
		reg_index = adr[APR_IDX_LSB +: APR_IDX_W];
	endfunction

	// byte-lane merge of a write into a 16-bit register
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old,
		input logic [31:0] wdat,
		input logic [3:0] lanes,
		input logic [15:0] mask
	);
		logic [15:0] merged;
		merged = old;
		if (lanes[0]) begin
			merged[7:0] = wdat[7:0];
		end
		if (lanes[1]) begin
			merged[15:8] = wdat[15:8];
		end
		lane_merge = merged & mask;
	endfunction

	// reads are latched at the edge that raises ack, writes land one edge later as ack drops
	assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
	assign rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff;
	assign idx = reg_index(wb_adr_i);
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// bus acknowledge, every address answers so the bus never hangs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
		end
	end

	// read data latched with the ack; the commit bit always reads zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdat_ff <= 32'h0000_0000;
		end else if (rd_req) begin
			// RULE19 unmapped and undefined bits read zero
			unique case (idx)
				APR_IDX_DAC_PATH: rdat_ff <= {16'h0000,
					dac_path_power_control_ff};
				APR_IDX_ROUTING: rdat_ff <= {16'h0000,
					port_routing_control_ff};
				APR_IDX_MIX_BOOST: rdat_ff <= {16'h0000,
					input_mixer_boost_control_ff};
				APR_IDX_LEFT_VOL: rdat_ff <= {16'h0000,
					left_input_pair_volume_ff};
				default: rdat_ff <= 32'h0000_0000;
			endcase
		end
	end

	// path and converter enables
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dac_path_power_control_ff <= APR_RST_DAC_PATH;
		end else if (wr_req && idx == APR_IDX_DAC_PATH) begin
			// RULE1 enable bits stored, others dropped
			dac_path_power_control_ff <= lane_merge(
				dac_path_power_control_ff, wb_dat_i, wb_sel_i,
				APR_MASK_DAC_PATH);
		end
	end

	// routing selectors; reserved codes are stored but route nothing
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			port_routing_control_ff <= APR_RST_ROUTING;
		end else if (wr_req && idx == APR_IDX_ROUTING) begin
			// RULE19 undefined routing bits ignored
			port_routing_control_ff <= lane_merge(
				port_routing_control_ff, wb_dat_i, wb_sel_i,
				APR_MASK_ROUTING);
		end
	end

	// mixer boost and clamp controls
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			input_mixer_boost_control_ff <= APR_RST_MIX_BOOST;
		end else if (wr_req && idx == APR_IDX_MIX_BOOST) begin
			// RULE14 clamp and boost bits stored
			input_mixer_boost_control_ff <= lane_merge(
				input_mixer_boost_control_ff, wb_dat_i, wb_sel_i,
				APR_MASK_MIX_BOOST);
		end
	end

	// left amp volume; the mask strips the self-clearing commit bit
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			left_input_pair_volume_ff <= APR_RST_LEFT_VOL;
		end else if (wr_req && idx == APR_IDX_LEFT_VOL) begin
			// RULE18 pending gain, mute and gate stored
			left_input_pair_volume_ff <= lane_merge(
				left_input_pair_volume_ff, wb_dat_i, wb_sel_i,
				APR_MASK_LEFT_VOL);
		end
	end

	// RULE15 commit request decode
	assign commit_write = wr_req && idx == APR_IDX_LEFT_VOL && wb_sel_i[1]
		&& wb_dat_i[APR_B_COMMIT];
	// RULE17 gate decides between now and next zero cross
	assign apply_now = (commit_write && !wb_dat_i[APR_B_ZC])
		|| (vol_state_ff == APR_VOL_WAIT_ZC && left_zero_cross);

	// commit sequencing; a new commit while waiting keeps waiting
	always_comb begin
		nxt_vol_state = vol_state_ff;
		unique case (vol_state_ff)
			APR_VOL_IDLE: begin
				if (commit_write && wb_dat_i[APR_B_ZC]) begin
					nxt_vol_state = APR_VOL_WAIT_ZC;
				end
			end
			APR_VOL_WAIT_ZC: begin
				if (left_zero_cross) begin
					nxt_vol_state = APR_VOL_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vol_state_ff <= APR_VOL_IDLE;
		end else begin
			vol_state_ff <= nxt_vol_state;
		end
	end

	// applied gain and the pulse that updates the right amp alongside
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			gain_ff <= APR_RST_GAIN;
			commit_ff <= 1'b0;
		end else begin
			commit_ff <= apply_now;
			if (apply_now) begin
				// RULE15 left applied with right commit pulse
				gain_ff <= commit_write ? wb_dat_i[APR_GAIN_W-1:0]
					: left_input_pair_volume_ff[APR_GAIN_W-1:0];
			end
		end
	end

	// controls handed to the data router
	always_comb begin
		route_bus.first_dac_l_on =
			dac_path_power_control_ff[APR_B_FIRST_DAC_L];
		route_bus.first_dac_r_on =
			dac_path_power_control_ff[APR_B_FIRST_DAC_R];
		route_bus.second_dac_l_on =
			dac_path_power_control_ff[APR_B_SECOND_DAC_L];
		route_bus.second_dac_r_on =
			dac_path_power_control_ff[APR_B_SECOND_DAC_R];
		route_bus.mono_sel = port_routing_control_ff[APR_F_MONO_LSB +: 2];
		route_bus.route_sel = port_routing_control_ff[APR_F_ROUTE_LSB +: 2];
		route_bus.rec_pin_sel =
			port_routing_control_ff[APR_F_REC_PIN_LSB +: 2];
		route_bus.second_rec_sel =
			port_routing_control_ff[APR_B_SECOND_REC];
		route_bus.second_play_sel =
			port_routing_control_ff[APR_B_SECOND_PLAY];
		route_bus.first_play_sel = port_routing_control_ff[APR_B_FIRST_PLAY];
	end

	// pin eight is taken as third port play data; software must assign it
	apr_route u_route (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.sel(route_bus.route),
		.first_play_pin(first_play_pin),
		.second_play_pin(second_play_pin),
		.third_port_play_data(shared_pin_eight_in),
		.first_rec_data(first_rec_data),
		.second_rec_data(second_rec_data),
		.second_adc_left(second_adc_left),
		.second_adc_right(second_adc_right),
		.first_dac_left_ff(first_dac_left_data),
		.first_dac_right_ff(first_dac_right_data),
		.second_dac_left_ff(second_dac_left_data),
		.second_dac_right_ff(second_dac_right_data),
		.second_rec_pin_ff(second_rec_pin_data),
		.third_rec_pin_ff(third_rec_data)
	);

	// pin nine: record data only when assigned, otherwise its other user
	always_comb begin
		if (pin_nine_is_record) begin
			shared_pin_nine_out = third_rec_data;
			// RULE5 float releases the assigned pin
			shared_pin_nine_oe_n = port_routing_control_ff[APR_B_FLOAT];
		end else begin
			// RULE6 float ignored for other functions
			shared_pin_nine_out = pin_nine_alt_out;
			shared_pin_nine_oe_n = pin_nine_alt_oe_n;
		end
	end

	// analogue controls straight from the stored bits; gain and commit from gain_ff and commit_ff
	assign left_converter_on = dac_path_power_control_ff[APR_B_CONV_L];
	assign right_converter_on = dac_path_power_control_ff[APR_B_CONV_R];
	// RULE12 right boost raises limit
	assign right_bypass_gain_boost =
		input_mixer_boost_control_ff[APR_B_BOOST_R];
	// RULE13 left boost raises limit
	assign left_bypass_gain_boost =
		input_mixer_boost_control_ff[APR_B_BOOST_L];
	// RULE14 clamp output
	assign inputs_clamp_on = input_mixer_boost_control_ff[APR_B_CLAMP];
	// RULE16 mute acts at once, not held for commit
	assign left_input_amp_mute = left_input_pair_volume_ff[APR_B_MUTE];
	assign left_input_zero_cross_gate = left_input_pair_volume_ff[APR_B_ZC];
	assign left_input_amp_gain = gain_ff;
	assign input_pair_volume_commit = commit_ff;

	// RULE15 commit reaches the applied gain next cycle
	a_commit_now: assert property (@(posedge ref_clk) disable iff (sys_rst)
		commit_write && !wb_dat_i[APR_B_ZC] |=> input_pair_volume_commit
		&& left_input_amp_gain == $past(wb_dat_i[APR_GAIN_W-1:0])) // RULE15
		else $error("commit did not apply gain");
	// RULE17 gated change waits for the zero cross
	a_zc_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
		vol_state_ff == APR_VOL_WAIT_ZC && !left_zero_cross
		|=> $stable(left_input_amp_gain)) // RULE17
		else $error("gain changed before zero cross");
	// RULE17 zero cross ends the wait
	a_zc_apply: assert property (@(posedge ref_clk) disable iff (sys_rst)
		vol_state_ff == APR_VOL_WAIT_ZC && left_zero_cross
		|=> input_pair_volume_commit ##1 !input_pair_volume_commit) // RULE17
		else $error("zero cross did not commit once");
	// RULE5 floated record pin is released
	a_float_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pin_nine_is_record && port_routing_control_ff[APR_B_FLOAT]
		|-> shared_pin_nine_oe_n) // RULE5
		else $error("floated record pin still driven");
	// RULE6 other function keeps its own enable
	a_float_other: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!pin_nine_is_record |-> shared_pin_nine_oe_n == pin_nine_alt_oe_n)
		// RULE6
		else $error("float touched a non third port pin");
	// RULE16 mute follows the register after a write
	a_mute_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_req && idx == APR_IDX_LEFT_VOL && wb_sel_i[0]
		|=> left_input_amp_mute == $past(wb_dat_i[APR_B_MUTE])) // RULE16
		else $error("mute did not follow write");
	// RULE19 unmapped read returns zero with an ack
	a_unmapped_rd: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rd_req && idx != APR_IDX_DAC_PATH && idx != APR_IDX_ROUTING
		&& idx != APR_IDX_MIX_BOOST && idx != APR_IDX_LEFT_VOL
		|=> wb_ack_o && wb_dat_o == 32'h0000_0000) // RULE19
		else $error("unmapped read not zero");
	// RULE1 ack is a single cycle pulse
	a_ack_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o) // RULE1
		else $error("ack held two cycles");
endmodule

// [logic/apr_route.sv]
`timescale 1ns/1ps
module apr_route
	import apr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	apr_route_if.route sel,
	input wire logic first_play_pin,
	input wire logic second_play_pin,
	input wire logic third_port_play_data,
	input wire logic first_rec_data,
	input wire logic second_rec_data,
	input wire logic second_adc_left,
	input wire logic second_adc_right,
	output logic first_dac_left_ff,
	output logic first_dac_right_ff,
	output logic second_dac_left_ff,
	output logic second_dac_right_ff,
	output logic second_rec_pin_ff,
	output logic third_rec_pin_ff
);
	logic first_play;
	logic second_play;
	logic mono;
	logic nxt_second_l;
	logic nxt_second_r;
	logic nxt_third_rec;

	// source pickers; pin eight always carries third port play data
	always_comb begin
		// RULE10 first play source
		first_play = sel.first_play_sel ? third_port_play_data : first_play_pin;
		// RULE9 second play source
		second_play = sel.second_play_sel ? third_port_play_data
			: second_play_pin;
		// RULE3 mono source, reserved code gives silence
		unique case (sel.mono_sel)
			APR_MONO_ADC_L: mono = second_adc_left;
			APR_MONO_ADC_R: mono = second_adc_right;
			default: mono = 1'b0;
		endcase
		// RULE4 second port input route, reserved code gives silence
		unique case (sel.route_sel)
			APR_ROUTE_BOTH_SECOND: begin
				nxt_second_l = second_play;
				nxt_second_r = second_play;
			end
			APR_ROUTE_R_THIRD: begin
				nxt_second_l = second_play;
				nxt_second_r = third_port_play_data;
			end
			APR_ROUTE_L_THIRD: begin
				nxt_second_l = third_port_play_data;
				nxt_second_r = second_play;
			end
			default: begin
				nxt_second_l = 1'b0;
				nxt_second_r = 1'b0;
			end
		endcase
		// RULE7 third port record pin source
		unique case (sel.rec_pin_sel)
			APR_REC_FIRST_ADC: nxt_third_rec = first_rec_data;
			APR_REC_SECOND_ADC: nxt_third_rec = second_rec_data;
			APR_REC_SECOND_DAC: nxt_third_rec = second_play;
			APR_REC_MONO: nxt_third_rec = mono;
		endcase
	end

	// registered outputs, disabled paths are held quiet
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			first_dac_left_ff <= 1'b0;
			first_dac_right_ff <= 1'b0;
			second_dac_left_ff <= 1'b0;
			second_dac_right_ff <= 1'b0;
			second_rec_pin_ff <= 1'b0;
			third_rec_pin_ff <= 1'b0;
		end else begin
			// RULE2 first port path gating
			first_dac_left_ff <= sel.first_dac_l_on & first_play;
			first_dac_right_ff <= sel.first_dac_r_on & first_play;
			// RULE1 second port path gating
			second_dac_left_ff <= sel.second_dac_l_on & nxt_second_l;
			second_dac_right_ff <= sel.second_dac_r_on & nxt_second_r;
			// RULE9 second record pin source
			second_rec_pin_ff <= sel.second_rec_sel ? third_port_play_data
				: second_rec_data;
			third_rec_pin_ff <= nxt_third_rec;
		end
	end

	// RULE1 disabled path stays quiet
	a_second_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!sel.second_dac_l_on |=> !second_dac_left_ff) // RULE1
		else $error("second port left path driven while off");
	// RULE7 mono code reaches record pin
	a_rec_mono: assert property (@(posedge ref_clk) disable iff (sys_rst)
		sel.rec_pin_sel == APR_REC_MONO && sel.mono_sel == APR_MONO_NONE
		|=> !third_rec_pin_ff) // RULE7
		else $error("record pin not silent with mono none");
endmodule

// [logic/apr_route_if.sv]
`timescale 1ns/1ps
interface apr_route_if;
	logic first_dac_l_on;
	logic first_dac_r_on;
	logic second_dac_l_on;
	logic second_dac_r_on;
	logic [1:0] mono_sel;
	logic [1:0] route_sel;
	logic [1:0] rec_pin_sel;
	logic second_rec_sel;
	logic second_play_sel;
	logic first_play_sel;

	modport ctl (
		output first_dac_l_on, first_dac_r_on, second_dac_l_on,
		output second_dac_r_on, mono_sel, route_sel, rec_pin_sel,
		output second_rec_sel, second_play_sel, first_play_sel
	);
	modport route (
		input first_dac_l_on, first_dac_r_on, second_dac_l_on,
		input second_dac_r_on, mono_sel, route_sel, rec_pin_sel,
		input second_rec_sel, second_play_sel, first_play_sel
	);
endinterface

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top
	import apr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	// sources: play1, play2, rec1, rec2, adc left, adc right, pin eight
	logic [6:0] src;
	logic pin_nine_is_record, pin_nine_alt_out, pin_nine_alt_oe_n;
	logic left_zero_cross;
	// routed outs: dac1 l, dac1 r, dac2 l, dac2 r, rec2 pin, pin nine
	wire [5:0] outs;
	wire conv_l, conv_r, boost_r, boost_l, clamp, mute, zc_gate;
	wire commit, nine_oe_n;
	wire [4:0] gain;
	int fail_count = 0;
	int samples_checked = 0;
	int commit_cnt = 0;

	// 125 MHz reference clock
	always #4 ref_clk = ~ref_clk;

	// count commit pulses so their number is judged, not their phase
	always @(posedge ref_clk) begin
		if (commit === 1'b1)
			commit_cnt <= commit_cnt + 1;
	end

	apr_regs dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .first_play_pin(src[0]),
		.second_play_pin(src[1]), .first_rec_data(src[2]),
		.second_rec_data(src[3]), .second_adc_left(src[4]),
		.second_adc_right(src[5]), .shared_pin_eight_in(src[6]),
		.first_dac_left_data(outs[0]), .first_dac_right_data(outs[1]),
		.second_dac_left_data(outs[2]), .second_dac_right_data(outs[3]),
		.second_rec_pin_data(outs[4]), .shared_pin_nine_out(outs[5]),
		.pin_nine_is_record(pin_nine_is_record),
		.pin_nine_alt_out(pin_nine_alt_out),
		.pin_nine_alt_oe_n(pin_nine_alt_oe_n),
		.shared_pin_nine_oe_n(nine_oe_n), .left_converter_on(conv_l),
		.right_converter_on(conv_r), .right_bypass_gain_boost(boost_r),
		.left_bypass_gain_boost(boost_l), .inputs_clamp_on(clamp),
		.left_zero_cross(left_zero_cross), .left_input_amp_mute(mute),
		.left_input_zero_cross_gate(zc_gate), .left_input_amp_gain(gain),
		.input_pair_volume_commit(commit)
	);

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string what);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one classic cycle; held until ack is sampled, then one idle cycle
	task automatic wb(input logic we, input logic [7:0] adr,
			input logic [15:0] wd, input logic [3:0] sel,
			output logic [31:0] rd);
		int n;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= {16'h0000, wd};
		wb_sel_i <= sel;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		rd = wb_dat_o;
		chk(32'(wb_ack_o), 32'h1, "ack");
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, 4'h3, x);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
			input string w);
		logic [31:0] x;
		wb(1'b0, a, 16'h0000, 4'h3, x);
		chk(x, e, w);
	endtask

	// reset values, masks, unmapped and lanes
	task automatic t_regs();
		logic [7:0] ad[4] = '{8'h14, 8'h18, 8'h54, 8'h60};
		logic [15:0] rs[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h008b};
		logic [15:0] mk[4] = '{16'h3303, 16'h07bf, 16'h01c0, 16'h00df};
		logic [31:0] x;
		chk(32'({mute, gain, outs}), 32'h0ac0, "reset outs");
		for (int i = 0; i < 4; i++)
			rdc(ad[i], 32'(rs[i]), "reset");
		// commit bit kept clear here so the applied gain stays put
		for (int i = 0; i < 4; i++) begin
			wr(ad[i], (i == 3) ? 16'hfeff : 16'hffff);
			rdc(ad[i], 32'(mk[i]), "mask");
		end
		chk(32'({conv_l, conv_r, boost_r, boost_l, clamp, mute, zc_gate}),
			32'h7f, "levels on");
		chk(32'(gain), 32'h0b, "pending gain");
		for (int i = 0; i < 4; i++)
			wr(ad[i], 16'h0000);
		chk(32'({conv_l, conv_r, boost_r, boost_l, clamp, mute, zc_gate}),
			32'h00, "levels off");
		wr(8'h7c, 16'hffff);
		rdc(8'h7c, 32'h0, "unmapped");
		rdc(8'h10, 32'h0, "unmapped");
		wb(1'b1, 8'h14, 16'hffff, 4'h1, x);
		rdc(8'h14, 32'h0003, "lane");
		wr(8'h14, 16'h0000);
		$display("test regs done");
	endtask

	// source selects walked with one-hot inputs
	task automatic t_route();
		logic [15:0] dc[10] = '{16'h3300, 16'h3300, 16'h3300, 16'h3300,
			16'h3300, 16'h3300, 16'h3300, 16'h3300, 16'h0000, 16'h2200};
		logic [15:0] rt[10] = '{16'h0000, 16'h0007, 16'h0088, 16'h0110,
			16'h0398, 16'h0418, 16'h0618, 16'h0018, 16'h0000, 16'h0000};
		// per output a nibble naming its source; 7 means held at zero
		logic [23:0] mp[10] = '{24'h231100, 24'h266666, 24'h336100,
			24'h131600, 24'h437700, 24'h531100, 24'h731100, 24'h731100,
			24'h237777, 24'h237170};
		logic [5:0] e;
		// pin nine assigned to record data
		pin_nine_is_record <= 1'b1;
		for (int c = 0; c < 10; c++) begin
			wr(8'h14, dc[c]);
			wr(8'h18, rt[c]);
			for (int k = 0; k < 7; k++) begin
				// pin eight carries third port play data
				src <= 7'h01 << k;
				repeat (2) @(posedge ref_clk);
				for (int j = 0; j < 6; j++)
					e[j] = (mp[c][4*j +: 4] == k);
				chk(32'(outs), 32'(e), "route");
			end
		end
		src <= 7'h00;
		$display("test route done");
	endtask

	// float bit only touches a pin nine in record use
	task automatic t_float();
		pin_nine_alt_out <= 1'b1;
		pin_nine_alt_oe_n <= 1'b0;
		wr(8'h18, 16'h0020);
		chk(32'(nine_oe_n), 32'h1, "float");
		pin_nine_is_record <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(32'({nine_oe_n, outs[5]}), 32'h1, "alt pin");
		pin_nine_alt_out <= 1'b0;
		pin_nine_alt_oe_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(32'({nine_oe_n, outs[5]}), 32'h2, "alt pin");
		pin_nine_is_record <= 1'b1;
		wr(8'h18, 16'h0000);
		chk(32'(nine_oe_n), 32'h0, "driven");
		$display("test float done");
	endtask

	// commit now, then commit held for a zero crossing
	task automatic t_vol();
		int c0;
		wr(8'h60, 16'h0085);
		chk(32'({mute, gain}), 32'h2b, "pending");
		c0 = commit_cnt;
		wr(8'h60, 16'h011f);
		chk(32'({zc_gate, mute, gain}), 32'h1f, "now");
		// the pulse counter settles one edge after the pulse is seen
		@(posedge ref_clk);
		chk(32'(commit_cnt - c0), 32'h1, "pulse");
		wr(8'h60, 16'h01c3);
		repeat (4) @(posedge ref_clk);
		chk(32'({zc_gate, mute, gain}), 32'h7f, "wait zc");
		left_zero_cross <= 1'b1;
		@(posedge ref_clk);
		left_zero_cross <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk(32'({zc_gate, mute, gain}), 32'h63, "on zc");
		chk(32'(commit_cnt - c0), 32'h2, "zc pulse");
		rdc(8'h60, 32'h00c3, "commit unread");
		$display("test volume done");
	endtask

	// watchdog sized well past the few hundred cycles the tests take
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		report_and_stop();
	end

	// reset for eight cycles, then the scenarios in turn
	initial begin
		sys_rst = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		src = 7'h00;
		pin_nine_is_record = 1'b0;
		pin_nine_alt_out = 1'b0;
		pin_nine_alt_oe_n = 1'b1;
		left_zero_cross = 1'b0;
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_route();
		t_float();
		t_vol();
		report_and_stop();
	end
endmodule
